//--- jtag_port_regs.vh
// Constants for the boundary-scan and programming test port
`ifndef JTAG_PORT_REGS_VH
`define JTAG_PORT_REGS_VH
// ***********************************************************
// Sizes
// ***********************************************************
`define IR_W 4
`define IO_NUM 96
`define IN_NUM 4
`define MC_NUM 128
`define ID_W 32
`define SIG_W 16
`define PROG_W 32
// ***********************************************************
// Instruction codes
// ***********************************************************
`define OP_EXTEST 4'h0
`define OP_SAMPLE 4'h1
`define OP_IDCODE 4'h2
`define OP_USERSIG 4'h3
`define OP_ISP_ENTER 4'h8
`define OP_ISP_DATA 4'h9
`define OP_ISP_EXIT 4'hA
`define OP_BYPASS 4'hF
// ***********************************************************
// Reset values and capture patterns
// ***********************************************************
`define IR_RST `OP_IDCODE
`define IR_CAPTURE 4'h1
`define SYNC_RST 3'h0
`endif

//--- boundary_cell.v
// One boundary cell: three capture/scan stages and its update stages
`timescale 1ns/10ps
module boundary_cell #(
   parameter MC_KIND = 0
) (
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire cap_en_i,
   input wire shift_en_i,
   input wire upd_en_i,
   input wire scan_i,
   input wire [2:0] cap_i,
   output wire scan_o,
   output wire [1:0] upd_o
);
   // Capture/scan stages, bit 0 nearest the output
   reg [2:0] cap_ff;
   // Update stages
   reg [1:0] upd_ff;

   // ***********************************************************
   // Capture and shift
   // ***********************************************************
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cap_ff <= 3'h0;
      end else if (cap_en_i) begin
         // Sample live signals
         cap_ff <= cap_i;
      end else if (shift_en_i) begin
         // Move one place toward the output
         cap_ff <= {scan_i, cap_ff[2:1]};
      end
   end

   // ***********************************************************
   // Update
   // ***********************************************************
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         upd_ff <= 2'h0;
      end else if (upd_en_i) begin
         // Macrocell variant keeps one update stage only
         upd_ff <= (MC_KIND != 0) ? {1'b0, cap_ff[1]} : cap_ff[2:1];
      end
   end

   assign scan_o = cap_ff[0];
   assign upd_o = upd_ff;
endmodule // boundary_cell

//--- jtag_port.v
// Test-access port with boundary-scan chain and programming access
`timescale 1ns/10ps
`include "jtag_port_regs.vh"
module jtag_port #(
   parameter [`ID_W-1:0] ID_VALUE = 32'h0000_0001 // Arbitrary value
) (
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire jtag_en_i,
   input wire hold_en_i,
   input wire tck_i,
   input wire tms_i,
   input wire tdi_i,
   output reg tdo_o,
   output reg tdo_oe_b_o,
   input wire user_tdo_i,
   input wire user_tdo_oe_i,
   output reg [2:0] user_pins_o,
   input wire [`IN_NUM-1:0] ded_in_i,
   input wire [`IO_NUM-1:0] io_in_i,
   output reg [`IN_NUM-1:0] ded_core_o,
   output reg [`IO_NUM-1:0] io_core_o,
   input wire [`IO_NUM-1:0] core_out_i,
   input wire [`IO_NUM-1:0] core_oe_i,
   output reg [`IO_NUM-1:0] io_out_o,
   output reg [`IO_NUM-1:0] io_oe_b_o,
   input wire [`MC_NUM-1:0] mc_fb_i,
   output wire [`MC_NUM-1:0] mc_force_o,
   input wire [`SIG_W-1:0] user_sig_i,
   output reg [`PROG_W-1:0] prog_data_o,
   output reg prog_we_o,
   output reg isp_active_o,
   output reg lock_o
);
   // One-hot controller states
   localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SELDR = 16'h0004,
      S_CAPDR = 16'h0008, S_SHDR = 16'h0010, S_EX1DR = 16'h0020,
      S_PADR = 16'h0040, S_EX2DR = 16'h0080, S_UPDR = 16'h0100,
      S_SELIR = 16'h0200, S_CAPIR = 16'h0400, S_SHIR = 16'h0800,
      S_EX1IR = 16'h1000, S_PAIR = 16'h2000, S_EX2IR = 16'h4000,
      S_UPIR = 16'h8000;
   localparam NCELL = `IN_NUM + `IO_NUM + `MC_NUM;

   // Three-stage synchronisers for clock, mode select, data in
   reg [2:0] s1_ff, s2_ff, s3_ff;
   // Filtered levels: bit 0 clock, 1 mode, 2 data
   reg [2:0] lvl_ff;
   reg [`IO_NUM-1:0] io_s1_ff, io_s2_ff;
   reg [`IN_NUM-1:0] in_s1_ff, in_s2_ff;
   // Controller state and instruction
   reg [15:0] state_ff, nxt_state;
   reg [`IR_W-1:0] ir_sh_ff, ir_ff;
   // Data registers
   reg byp_ff;
   reg [`ID_W-1:0] id_sh_ff;
   reg [`SIG_W-1:0] sig_sh_ff;
   reg [`PROG_W-1:0] prog_sh_ff;
   // Pin levels held for programming
   reg [`IO_NUM-1:0] hold_out_ff, hold_oe_ff;
   // Edge events and cell controls
   wire tck_rise, tck_fall, tms, tdi;
   wire sel_bsr, cap_en, shift_en, upd_en;
   wire [NCELL:0] chain;
   wire [2*`IO_NUM-1:0] io_upd;
   wire [2*`MC_NUM-1:0] mc_upd;
   // Update-stage pin value and enable, split per pin
   wire [`IO_NUM-1:0] ext_out, ext_oe;
   reg dr_lsb;

   // ***********************************************************
   // Pin synchronisers and edge detection
   // ***********************************************************
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_ff <= `SYNC_RST;
         s2_ff <= `SYNC_RST;
         s3_ff <= `SYNC_RST;
         lvl_ff <= `SYNC_RST;
      end else begin
         s1_ff <= {tdi_i, tms_i, tck_i};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         // A change counts once stages two and three agree
         lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
      end
   end
   assign tck_rise = s2_ff[0] & s3_ff[0] & ~lvl_ff[0] & jtag_en_i;
   assign tck_fall = ~s2_ff[0] & ~s3_ff[0] & lvl_ff[0] & jtag_en_i;
   assign tms = lvl_ff[1];
   assign tdi = lvl_ff[2];

   // User-pin inputs: three flops to the core
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         io_s1_ff <= {`IO_NUM{1'b0}};
         io_s2_ff <= {`IO_NUM{1'b0}};
         io_core_o <= {`IO_NUM{1'b0}};
         in_s1_ff <= {`IN_NUM{1'b0}};
         in_s2_ff <= {`IN_NUM{1'b0}};
         ded_core_o <= {`IN_NUM{1'b0}};
      end else begin
         io_s1_ff <= io_in_i;
         io_s2_ff <= io_s1_ff;
         io_core_o <= io_s2_ff;
         in_s1_ff <= ded_in_i;
         in_s2_ff <= in_s1_ff;
         ded_core_o <= in_s2_ff;
      end
   end

   // ***********************************************************
   // Controller
   // ***********************************************************
   // Sixteen-state step
   always @* begin
      case (state_ff)
         S_TLR: nxt_state = tms ? S_TLR : S_RTI;
         S_RTI: nxt_state = tms ? S_SELDR : S_RTI;
         S_SELDR: nxt_state = tms ? S_SELIR : S_CAPDR;
         S_CAPDR: nxt_state = tms ? S_EX1DR : S_SHDR;
         S_SHDR: nxt_state = tms ? S_EX1DR : S_SHDR;
         S_EX1DR: nxt_state = tms ? S_UPDR : S_PADR;
         S_PADR: nxt_state = tms ? S_EX2DR : S_PADR;
         S_EX2DR: nxt_state = tms ? S_UPDR : S_SHDR;
         S_UPDR: nxt_state = tms ? S_SELDR : S_RTI;
         S_SELIR: nxt_state = tms ? S_TLR : S_CAPIR;
         S_CAPIR: nxt_state = tms ? S_EX1IR : S_SHIR;
         S_SHIR: nxt_state = tms ? S_EX1IR : S_SHIR;
         S_EX1IR: nxt_state = tms ? S_UPIR : S_PAIR;
         S_PAIR: nxt_state = tms ? S_EX2IR : S_PAIR;
         S_EX2IR: nxt_state = tms ? S_UPIR : S_SHIR;
         S_UPIR: nxt_state = tms ? S_SELDR : S_RTI;
         default: nxt_state = S_TLR;
      endcase
   end

   // State and instruction registers
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff <= S_TLR;
         ir_sh_ff <= `IR_CAPTURE;
         ir_ff <= `IR_RST;
      end else if (!jtag_en_i) begin
         state_ff <= S_TLR;
         ir_ff <= `IR_RST;
      end else begin
         // Mode sampled on rising test clock
         if (tck_rise) begin
            state_ff <= nxt_state;
            if (state_ff == S_CAPIR) begin
               ir_sh_ff <= `IR_CAPTURE;
            end else if (state_ff == S_SHIR) begin
               ir_sh_ff <= {tdi, ir_sh_ff[`IR_W-1:1]};
            end
         end
         if (tck_fall && state_ff == S_UPIR) begin
            ir_ff <= ir_sh_ff;
         end else if (state_ff == S_TLR) begin
            ir_ff <= `IR_RST;
         end
      end
   end

   // ***********************************************************
   // Data registers other than the boundary chain
   // ***********************************************************
   // Bypass, identification; signature always readable
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         byp_ff <= 1'b0;
         id_sh_ff <= {`ID_W{1'b0}};
         sig_sh_ff <= {`SIG_W{1'b0}};
         prog_sh_ff <= {`PROG_W{1'b0}};
      end else if (tck_rise && state_ff == S_CAPDR) begin
         byp_ff <= 1'b0;
         id_sh_ff <= ID_VALUE;
         sig_sh_ff <= user_sig_i;
      end else if (tck_rise && state_ff == S_SHDR) begin
         byp_ff <= tdi;
         id_sh_ff <= {tdi, id_sh_ff[`ID_W-1:1]};
         sig_sh_ff <= {tdi, sig_sh_ff[`SIG_W-1:1]};
         // Programming data only via the test pins
         if (ir_ff == `OP_ISP_DATA) begin
            prog_sh_ff <= {tdi, prog_sh_ff[`PROG_W-1:1]};
         end
      end
   end

   // Output bit of the selected data register
   always @* begin
      case (ir_ff)
         `OP_EXTEST, `OP_SAMPLE: dr_lsb = chain[NCELL];
         `OP_IDCODE: dr_lsb = id_sh_ff[0];
         `OP_USERSIG: dr_lsb = sig_sh_ff[0];
         `OP_ISP_DATA: dr_lsb = prog_sh_ff[0];
         default: dr_lsb = byp_ff;
      endcase
   end

   // ***********************************************************
   // Boundary chain
   // ***********************************************************
   // Cell controls made here from controller state
   assign sel_bsr = (ir_ff == `OP_EXTEST) || (ir_ff == `OP_SAMPLE);
   assign cap_en = sel_bsr & tck_rise & (state_ff == S_CAPDR);
   assign shift_en = sel_bsr & tck_rise & (state_ff == S_SHDR);
   assign upd_en = sel_bsr & tck_fall & (state_ff == S_UPDR);
   // Chain from data in to data out
   assign chain[0] = tdi;

   genvar gi;
   generate
      // One pin cell per dedicated input
      for (gi = 0; gi < `IN_NUM; gi = gi + 1) begin : g_in
         boundary_cell #(.MC_KIND(0)) u_cell (
            .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cap_en_i(cap_en),
            .shift_en_i(shift_en), .upd_en_i(upd_en), .scan_i(chain[gi]),
            .cap_i({2'h0, in_s2_ff[gi]}), .scan_o(chain[gi+1]), .upd_o());
      end
      // One pin cell per I/O pin
      for (gi = 0; gi < `IO_NUM; gi = gi + 1) begin : g_io
         boundary_cell #(.MC_KIND(0)) u_cell (
            .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cap_en_i(cap_en),
            .shift_en_i(shift_en), .upd_en_i(upd_en),
            .scan_i(chain[`IN_NUM+gi]),
            .cap_i({core_oe_i[gi], core_out_i[gi], io_s2_ff[gi]}),
            .scan_o(chain[`IN_NUM+gi+1]), .upd_o(io_upd[2*gi+1:2*gi]));
         // Update bit 0 is pin value, bit 1 its enable
         assign ext_out[gi] = io_upd[2*gi];
         assign ext_oe[gi] = io_upd[2*gi+1];
      end
      for (gi = 0; gi < `MC_NUM; gi = gi + 1) begin : g_mc
         boundary_cell #(.MC_KIND(1)) u_cell (
            .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cap_en_i(cap_en),
            .shift_en_i(shift_en), .upd_en_i(upd_en),
            .scan_i(chain[`IN_NUM+`IO_NUM+gi]),
            .cap_i({1'b0, mc_fb_i[gi], mc_fb_i[gi]}),
            .scan_o(chain[`IN_NUM+`IO_NUM+gi+1]), .upd_o(mc_upd[2*gi+1:2*gi]));
         assign mc_force_o[gi] = mc_upd[2*gi];
      end
   endgenerate

   // ***********************************************************
   // Programming session and lock
   // ***********************************************************
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         isp_active_o <= 1'b0;
         lock_o <= 1'b0;
         prog_we_o <= 1'b0;
         prog_data_o <= {`PROG_W{1'b0}};
         hold_out_ff <= {`IO_NUM{1'b0}};
         hold_oe_ff <= {`IO_NUM{1'b0}};
      end else begin
         prog_we_o <= 1'b0;
         if (isp_active_o && (!jtag_en_i || state_ff == S_TLR)) begin
            isp_active_o <= 1'b0;
            lock_o <= 1'b1;
         end else if (tck_fall && state_ff == S_UPDR) begin
            if (ir_ff == `OP_ISP_ENTER && !isp_active_o) begin
               isp_active_o <= 1'b1;
               hold_out_ff <= io_out_o;
               hold_oe_ff <= ~io_oe_b_o;
            end else if (ir_ff == `OP_ISP_DATA && isp_active_o) begin
               prog_data_o <= prog_sh_ff;
               prog_we_o <= 1'b1;
            end else if (ir_ff == `OP_ISP_EXIT && isp_active_o) begin
               // Clean finish releases the lock
               isp_active_o <= 1'b0;
               lock_o <= 1'b0;
            end
         end
      end
   end

   // ***********************************************************
   // Pin drivers
   // ***********************************************************
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         io_out_o <= {`IO_NUM{1'b0}};
         io_oe_b_o <= {`IO_NUM{1'b1}};
      end else if (lock_o) begin
         io_oe_b_o <= {`IO_NUM{1'b1}};
      end else if (isp_active_o) begin
         // Hold option keeps levels, else release
         io_out_o <= hold_out_ff;
         io_oe_b_o <= hold_en_i ? ~hold_oe_ff : {`IO_NUM{1'b1}};
      end else if (ir_ff == `OP_EXTEST) begin
         io_out_o <= ext_out;
         io_oe_b_o <= ~ext_oe;
      end else begin
         io_out_o <= core_out_i;
         io_oe_b_o <= ~core_oe_i;
      end
   end

   // ***********************************************************
   // Test data out and shared pins
   // ***********************************************************
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tdo_o <= 1'b0;
         tdo_oe_b_o <= 1'b1;
         user_pins_o <= 3'h0;
      end else if (!jtag_en_i) begin
         tdo_o <= user_tdo_i;
         tdo_oe_b_o <= ~user_tdo_oe_i;
         user_pins_o <= lvl_ff;
      end else if (tck_fall) begin
         tdo_o <= (state_ff == S_SHIR) ? ir_sh_ff[0] : dr_lsb;
         tdo_oe_b_o <= ~((state_ff == S_SHIR) || (state_ff == S_SHDR));
      end
   end
endmodule // jtag_port

//--- jtag_port_checker.sv
// Concurrent checks on the test port pins and programming outputs
`timescale 1ns/10ps
module jtag_port_checker (
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire jtag_en_i,
   input wire hold_en_i,
   input wire [95:0] core_out_i,
   input wire [95:0] core_oe_i,
   input wire [95:0] io_out_o,
   input wire [95:0] io_oe_b_o,
   input wire prog_we_o,
   input wire isp_active_o,
   input wire lock_o
);
   // ***********************************************************
   // Checks, all in the system clock domain
   // ***********************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // No session and no lock
   sequence s_idle;
      !lock_o && !isp_active_o;
   endsequence
   // Port switched off while a session is open
   sequence s_abort;
      isp_active_o && !jtag_en_i;
   endsequence
   a_lock_float: assert property (lock_o && $past(lock_o) |-> &io_oe_b_o)
      else $error("pins driven while locked");
   a_abort_locks: assert property (s_abort |=> lock_o && !isp_active_o)
      else $error("abort did not lock");
   a_lock_stays: assert property (lock_o && !isp_active_o |=> lock_o)
      else $error("lock dropped outside a session");
   a_core_pass: assert property ((s_idle && !jtag_en_i) ##1 (s_idle && !jtag_en_i) |->
      io_out_o == $past(core_out_i) && io_oe_b_o == ~$past(core_oe_i))
      else $error("pins do not follow the core");
   a_off_closed: assert property (!jtag_en_i ##1 !jtag_en_i |-> !isp_active_o)
      else $error("session open with port disabled");
   a_hold_float: assert property (isp_active_o && $past(isp_active_o) &&
      !hold_en_i && !$past(hold_en_i) |-> &io_oe_b_o)
      else $error("pins driven while programming without hold");
   a_held_level: assert property (isp_active_o && $past(isp_active_o) &&
      $past(isp_active_o, 2) |-> $stable(io_out_o))
      else $error("pin level moved while programming");
   a_we_pulse: assert property (prog_we_o |=> !prog_we_o)
      else $error("write strobe longer than one cycle");
   a_we_session: assert property (prog_we_o |-> isp_active_o)
      else $error("write strobe outside a session");
endmodule // jtag_port_checker
bind jtag_port jtag_port_checker u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .jtag_en_i(jtag_en_i), .hold_en_i(hold_en_i), .core_out_i(core_out_i),
   .core_oe_i(core_oe_i), .io_out_o(io_out_o), .io_oe_b_o(io_oe_b_o),
   .prog_we_o(prog_we_o), .isp_active_o(isp_active_o), .lock_o(lock_o));

//--- jtag_tester.sv
// Model of the outside tester that steps the test port
`timescale 1ns/10ps
module jtag_tester (
   input wire sys_clk_i,
   input wire tdo_i,
   input wire tdo_oe_b_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   // Test clock stands low until the first frame
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   // one 800 ns period, lines set at the fall, TDO read before next fall
   task automatic bit_io(input logic m, input logic d, output logic o);
      @(posedge sys_clk_i);
      tck_o <= 1'b0;
      tms_o <= m;
      tdi_o <= d;
      repeat (4) @(posedge sys_clk_i);
      tck_o <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      // A released TDO has no pull, so it reads as the inverse
      o = tdo_oe_b_i ? ~tdo_i : tdo_i;
   endtask
   // Shift n bits, first bit first, leaving shift on the last
   task automatic shift(input int n, input logic [31:0] din, input logic fill,
      output logic [31:0] dout);
      logic b;
      dout = 32'h0000_0000;
      for (int i = 0; i < n; i++) begin
         bit_io(i == n - 1, (i < 32) ? din[i] : fill, b);
         if (i < 32) dout[i] = b;
      end
   endtask
endmodule // jtag_tester

//--- test_jtag_port.sv
// Self-checking bench for the test port
`timescale 1ns/10ps
`include "jtag_port_regs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module test_jtag_port;
   localparam logic [31:0] ID_TEST = 32'h3c5a_0e01; // Arbitrary value
   logic sys_clk_i = 1'b0, rst_b_i = 1'b0, jtag_en_i = 1'b0, hold_en_i = 1'b0;
   logic user_tdo_i = 1'b0, user_tdo_oe_i = 1'b0;
   logic [3:0] ded_in_i = 4'h0;
   logic [95:0] io_in_i = 96'h0, core_out_i = 96'h0, core_oe_i = 96'h0;
   logic [127:0] mc_fb_i = {128{1'b1}};
   logic [15:0] user_sig_i = 16'h0000;
   wire tck_i, tms_i, tdi_i, tdo_o, tdo_oe_b_o, prog_we_o, isp_active_o, lock_o;
   wire [2:0] user_pins_o;
   wire [3:0] ded_core_o;
   wire [95:0] io_core_o, io_out_o, io_oe_b_o;
   wire [127:0] mc_force_o;
   wire [31:0] prog_data_o;
   int n_errors = 0, total_checks = 0;
   logic [31:0] seed = 32'h1b0e_26e0, r, w, g, e;
   logic [31:0] exp_q[$], got_q[$], pq[$];
   // ***********************************************************
   // Clock, random pin traffic, design and tester
   // ***********************************************************
   initial forever #50 sys_clk_i = ~sys_clk_i;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // New pin values every cycle; signature fixed once reset ends
   always @(posedge sys_clk_i) begin
      seed = xs(seed);
      core_out_i <= {3{seed}};
      core_oe_i <= {3{seed[15:0], seed[31:16]}};
      io_in_i <= {3{~seed}};
      ded_in_i <= seed[7:4];
      user_tdo_i <= seed[9];
      user_tdo_oe_i <= seed[11];
      if (!rst_b_i) user_sig_i <= seed[23:8];
   end
   jtag_port #(.ID_VALUE(ID_TEST)) u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .jtag_en_i(jtag_en_i), .hold_en_i(hold_en_i), .tck_i(tck_i), .tms_i(tms_i),
      .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_b_o(tdo_oe_b_o), .user_tdo_i(user_tdo_i),
      .user_tdo_oe_i(user_tdo_oe_i), .user_pins_o(user_pins_o), .ded_in_i(ded_in_i),
      .io_in_i(io_in_i), .ded_core_o(ded_core_o), .io_core_o(io_core_o),
      .core_out_i(core_out_i), .core_oe_i(core_oe_i), .io_out_o(io_out_o),
      .io_oe_b_o(io_oe_b_o), .mc_fb_i(mc_fb_i), .mc_force_o(mc_force_o),
      .user_sig_i(user_sig_i), .prog_data_o(prog_data_o), .prog_we_o(prog_we_o),
      .isp_active_o(isp_active_o), .lock_o(lock_o));
   jtag_tester u_tester (.sys_clk_i(sys_clk_i), .tdo_i(tdo_o), .tdo_oe_b_i(tdo_oe_b_o),
      .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i));
   // Compare each result with the oldest note
   always @(posedge sys_clk_i) begin
      while (got_q.size() > 0) begin
         g = got_q.pop_front();
         e = exp_q.pop_front();
         `CHK(g, e)
      end
      if (prog_we_o === 1'b1) `CHK(prog_data_o, pq.pop_front())
   end
   task automatic note(input logic [31:0] ev, input logic [31:0] gv);
      exp_q.push_back(ev);
      got_q.push_back(gv);
   endtask
   // TMS walk, first bit first
   task automatic walk(input logic [7:0] t, input int n);
      logic b;
      for (int i = 0; i < n; i++) u_tester.bit_io(t[i], 1'b0, b);
   endtask
   task automatic ir(input logic [3:0] c);
      logic [31:0] cap;
      walk(8'h03, 4);
      u_tester.shift(4, {28'h000_0000, c}, 1'b0, cap);
      walk(8'h01, 2);
      note(32'h0000_0001, cap);
   endtask
   task automatic dr(input int n, input logic [31:0] d, input logic f, output logic [31:0] q);
      walk(8'h01, 3);
      u_tester.shift(n, d, f, q);
      walk(8'h01, 2);
      repeat (3) @(posedge sys_clk_i);
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Bound on the whole run
   initial begin
      repeat (90000) @(posedge sys_clk_i);
      n_errors++;
      $display("wrong value at %0t: run did not finish", $time);
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      // Port starts disabled, so pins follow the core for a while
      repeat (8) @(posedge sys_clk_i);
      jtag_en_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      walk(8'h00, 1);
      dr(32, 32'h0000_0000, 1'b0, r);
      note(ID_TEST, r);
      ir(`OP_USERSIG);
      dr(16, 32'h0000_0000, 1'b0, r);
      note({16'h0000, user_sig_i}, r);
      $display("test ident done");
      for (int c = 4; c < 16; c++) if (c < 8 || c > 10) begin
         ir(c[3:0]);
         dr(8, 32'h0000_00a5, 1'b0, r);
         note(32'h0000_004a, r);
      end
      $display("test bypass done");
      for (int k = 0; k < 2; k++) begin
         ir(k ? `OP_EXTEST : `OP_SAMPLE);
         if (k) note(32'h0000_0001, {31'h0000_0000, (&io_out_o) && !(|io_oe_b_o)});
         dr(684, {32{k == 0}}, k == 0, r);
         note(32'hdb6d_b6db, r);
         note(32'h0000_0001, {31'h0000_0000, mc_force_o === {128{k == 0}}});
      end
      $display("test chain done");
      ir(`OP_ISP_ENTER);
      dr(32, 32'h0000_0000, 1'b0, r);
      note(32'h0000_0002, {30'h0000_0000, isp_active_o, lock_o});
      ir(`OP_ISP_DATA);
      for (int k = 0; k < 2; k++) begin
         w = xs(seed);
         pq.push_back(w);
         dr(32, w, 1'b0, r);
      end
      ir(`OP_ISP_EXIT);
      dr(32, 32'h0000_0000, 1'b0, r);
      note(32'h0000_0000, {30'h0000_0000, isp_active_o, lock_o});
      ir(`OP_ISP_ENTER);
      dr(32, 32'h0000_0000, 1'b0, r);
      walk(8'h1f, 5);
      note(32'h0000_0001, {30'h0000_0000, isp_active_o, lock_o});
      note(32'h0000_0001, {31'h0000_0000, &io_oe_b_o});
      walk(8'h00, 1);
      ir(`OP_ISP_ENTER);
      dr(32, 32'h0000_0000, 1'b0, r);
      jtag_en_i <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      note(32'h0000_0001, {30'h0000_0000, isp_active_o, lock_o});
      note({29'h0000_0000, tdi_i, tms_i, tck_i}, {29'h0000_0000, user_pins_o});
      repeat (2) @(posedge sys_clk_i);
      $display("test programming done");
      end_of_test();
   end
endmodule // test_jtag_port
